// File: pwm_meas_pkg.sv
// Package for the pulse width measurement timer channel.
// Holds register offsets, field positions, reset values, codes and carriers.
package pwm_meas_pkg;

	// ------------------------------------------------------------------
	// Register byte offsets
	// ------------------------------------------------------------------
	localparam logic [7:0] OFS_TIMER_CONTROL   = 8'h00;
	localparam logic [7:0] OFS_STATUS_CONTROL  = 8'h04;
	localparam logic [7:0] OFS_RESULT_BUFFER   = 8'h08;
	localparam logic [7:0] OFS_RESULT_BUFFER_H = 8'h0C;

	// ------------------------------------------------------------------
	// Field positions: timer_control
	// ------------------------------------------------------------------
	localparam int CTL_RUN_BIT     = 1;
	localparam int CTL_ONESHOT_BIT = 2;
	localparam int CTL_FMD_LSB     = 4;
	localparam int CTL_WIDE_BIT    = 7;
	localparam int CTL_EGS_LSB     = 8;
	localparam int CTL_CKS_LSB     = 12;

	// ------------------------------------------------------------------
	// Field positions: status_control (timer_control_ext in bits 15:8)
	// ------------------------------------------------------------------
	localparam int STS_OVF_BIT     = 0;
	localparam int STS_DONE_BIT    = 2;
	localparam int STS_OVF_IE_BIT  = 4;
	localparam int STS_DONE_IE_BIT = 6;
	localparam int STS_ERR_BIT     = 7;
	localparam int STS_CLOCK_SELECT_B3_BIT    = 8;

	// ------------------------------------------------------------------
	// Reset values and counter constants
	// ------------------------------------------------------------------
	localparam logic [15:0] TIMER_CONTROL_RST = 16'h0000;
	localparam logic [31:0] COUNT_CLEAR       = 32'h0000_0000;
	localparam logic [31:0] COUNT_FIRST       = 32'h0000_0001;
	localparam logic [31:0] COUNT_MAX16       = 32'h0000_FFFF;
	localparam logic [31:0] COUNT_MAX32       = 32'hFFFF_FFFF;
	localparam int          PRESC_W           = 11;

	// ------------------------------------------------------------------
	// Codes
	// ------------------------------------------------------------------
	typedef enum logic [2:0] {
		EDGE_HIGH  = 3'b000,
		EDGE_RISE  = 3'b001,
		EDGE_FALL  = 3'b010,
		EDGE_ANY   = 3'b011,
		EDGE_LOW   = 3'b100
	} edge_sel_t;

	localparam logic [2:0] FMD_PULSE_MEASURE = 3'b100;

	typedef enum logic [1:0] {
		ST_IDLE    = 2'b00,
		ST_WAIT    = 2'b01,
		ST_MEASURE = 2'b10,
		ST_HALTED  = 2'b11
	} meas_state_t;

	// ------------------------------------------------------------------
	// Carriers
	// ------------------------------------------------------------------
	typedef struct packed {
		logic [3:0] clock_select;
		logic [2:0] edge_select;
		logic       wide_pair_select;
		logic [2:0] function_select;
		logic       oneshot_select;
		logic       run_enable;
	} ctrl_t;

	typedef struct packed {
		logic overrun;
		logic completion_irq_enable;
		logic overflow_irq_enable;
		logic completion_flag;
		logic overflow_flag;
	} status_t;

endpackage

// File: pulse_width_measurement_timer.sv
// Pulse width and cycle measurement timer channel with an APB register slave.
// Assumes pulse_in is synchronous to pclk; APB master keeps standard signalling.
//
// Design decisions made here: the APB register port and the address map.

`timescale 1ns/10ps
`default_nettype none

module pulse_width_measurement_timer (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        clk_en,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        pulse_in,
	output logic             irq_overflow,
	output logic             irq_complete
);

	// ------------------------------------------------------------------
	// Bus decode
	// ------------------------------------------------------------------
	pwm_meas_pkg::ctrl_t       ctrl_q;
	pwm_meas_pkg::status_t     sts_q;
	pwm_meas_pkg::meas_state_t state_q;
	logic [31:0]               count_q;
	logic [31:0]               buffer_q;
	logic [2:0]                sync_q;
	logic [pwm_meas_pkg::PRESC_W-1:0] presc_q;

	logic access;
	logic wr;
	logic rd;
	logic sel_ctl;
	logic sel_sts;
	logic sel_buf;
	logic sel_bufh;
	logic mapped;
	logic buf_read;

	assign access   = psel & penable & clk_en;
	assign wr       = access & pwrite;
	assign rd       = access & ~pwrite;
	assign sel_ctl  = paddr == pwm_meas_pkg::OFS_TIMER_CONTROL;
	assign sel_sts  = paddr == pwm_meas_pkg::OFS_STATUS_CONTROL;
	assign sel_buf  = paddr == pwm_meas_pkg::OFS_RESULT_BUFFER;
	assign sel_bufh = paddr == pwm_meas_pkg::OFS_RESULT_BUFFER_H;
	assign mapped   = sel_ctl | sel_sts | sel_buf | sel_bufh;
	assign buf_read = rd & sel_buf;
	assign pready   = clk_en;
	assign pslverr  = psel & penable & ~mapped;

	// ------------------------------------------------------------------
	// Control register writes
	// ------------------------------------------------------------------
	logic ctl_wr;
	logic run_wr1;
	logic restart;
	logic start_wr;
	logic stop_wr;
	logic meas_fn_wr;

	assign ctl_wr   = wr & sel_ctl & pstrb[0];
	assign run_wr1  = ctl_wr & pwdata[pwm_meas_pkg::CTL_RUN_BIT];
	assign restart  = run_wr1 & ctrl_q.run_enable;
	assign start_wr = run_wr1 & ~ctrl_q.run_enable;
	assign stop_wr  = ctl_wr & ~pwdata[pwm_meas_pkg::CTL_RUN_BIT];
	assign meas_fn_wr = pwdata[pwm_meas_pkg::CTL_FMD_LSB +: 3] == pwm_meas_pkg::FMD_PULSE_MEASURE;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= pwm_meas_pkg::ctrl_t'(pwm_meas_pkg::TIMER_CONTROL_RST[12:0]);
		end else if (clk_en) begin
			if (wr && sel_ctl && pstrb[1]) begin
				ctrl_q.clock_select[2:0] <= pwdata[pwm_meas_pkg::CTL_CKS_LSB +: 3];
				ctrl_q.edge_select       <= pwdata[pwm_meas_pkg::CTL_EGS_LSB +: 3];
			end
			if (ctl_wr) begin
				ctrl_q.wide_pair_select <= pwdata[pwm_meas_pkg::CTL_WIDE_BIT];
				ctrl_q.function_select  <= pwdata[pwm_meas_pkg::CTL_FMD_LSB +: 3];
				ctrl_q.oneshot_select   <= pwdata[pwm_meas_pkg::CTL_ONESHOT_BIT];
				ctrl_q.run_enable       <= pwdata[pwm_meas_pkg::CTL_RUN_BIT];
			end
			if (wr && sel_sts && pstrb[1]) begin
				ctrl_q.clock_select[3] <= pwdata[pwm_meas_pkg::STS_CLOCK_SELECT_B3_BIT];
			end
		end
	end

	// ------------------------------------------------------------------
	// Count clock prescaler
	// ------------------------------------------------------------------
	logic [3:0]                       shift;
	logic                             sel_ok;
	logic [pwm_meas_pkg::PRESC_W-1:0] mask;
	logic                             tick;

	always_comb begin
		sel_ok = 1'b1;
		unique case (ctrl_q.clock_select)
			4'h0:    shift = 4'd0;
			4'h1:    shift = 4'd2;
			4'h2:    shift = 4'd4;
			4'h3:    shift = 4'd7;
			4'h4:    shift = 4'd8;
			4'h8:    shift = 4'd9;
			4'h9:    shift = 4'd10;
			4'hA:    shift = 4'd11;
			default: begin
				shift  = 4'd0;
				sel_ok = 1'b0;
			end
		endcase
	end

	assign mask = pwm_meas_pkg::PRESC_W'((12'h001 << shift) - 12'h001);
	assign tick = sel_ok && ((presc_q & mask) == mask);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			presc_q <= '0;
		end else if (clk_en) begin
			presc_q <= run_wr1 ? '0 : presc_q + 1'b1;
		end
	end

	// ------------------------------------------------------------------
	// Input synchroniser and edge qualification
	// ------------------------------------------------------------------
	logic rise;
	logic fall;
	logic start_edge;
	logic end_edge;
	logic edge_ok;
	logic chain;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync_q <= 3'b000;
		end else if (clk_en) begin
			sync_q <= {sync_q[1:0], pulse_in};
		end
	end

	assign rise = sync_q[1] & ~sync_q[2];
	assign fall = ~sync_q[1] & sync_q[2];

	always_comb begin
		edge_ok = 1'b1;
		chain   = 1'b0;
		unique case (ctrl_q.edge_select)
			pwm_meas_pkg::EDGE_HIGH: begin
				start_edge = rise;
				end_edge   = fall;
			end
			pwm_meas_pkg::EDGE_RISE: begin
				start_edge = rise;
				end_edge   = rise;
				chain      = 1'b1;
			end
			pwm_meas_pkg::EDGE_FALL: begin
				start_edge = fall;
				end_edge   = fall;
				chain      = 1'b1;
			end
			pwm_meas_pkg::EDGE_ANY: begin
				start_edge = rise | fall;
				end_edge   = rise | fall;
				chain      = 1'b1;
			end
			pwm_meas_pkg::EDGE_LOW: begin
				start_edge = fall;
				end_edge   = rise;
			end
			default: begin
				start_edge = 1'b0;
				end_edge   = 1'b0;
				edge_ok    = 1'b0;
			end
		endcase
	end

	// ------------------------------------------------------------------
	// Measurement sequencer
	// ------------------------------------------------------------------
	logic        active;
	logic        wide;
	logic        meas_end;
	logic        wrap;
	logic        oneshot;
	logic [31:0] max_count;

	assign active    = ctrl_q.function_select == pwm_meas_pkg::FMD_PULSE_MEASURE;
	assign wide      = ctrl_q.wide_pair_select;
	assign max_count = wide ? pwm_meas_pkg::COUNT_MAX32 : pwm_meas_pkg::COUNT_MAX16;
	assign oneshot   = ctrl_q.oneshot_select;
	assign meas_end  = active && edge_ok && state_q == pwm_meas_pkg::ST_MEASURE && end_edge;
	assign wrap      = state_q == pwm_meas_pkg::ST_MEASURE && !meas_end && tick
		&& count_q == max_count && !restart;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= pwm_meas_pkg::ST_IDLE;
		end else if (clk_en) begin
			if (stop_wr) begin
				state_q <= pwm_meas_pkg::ST_IDLE;
			end else if (start_wr) begin
				// Function field may arrive with the run write
				state_q <= meas_fn_wr ? pwm_meas_pkg::ST_WAIT
					: pwm_meas_pkg::ST_IDLE;
			end else if (!active) begin
				state_q <= pwm_meas_pkg::ST_IDLE;
			end else if (restart) begin
				if (state_q != pwm_meas_pkg::ST_MEASURE || meas_end) begin
					state_q <= (state_q == pwm_meas_pkg::ST_MEASURE)
						? pwm_meas_pkg::ST_WAIT : state_q;
				end else begin
					state_q <= pwm_meas_pkg::ST_WAIT;
				end
			end else begin
				unique case (state_q)
					pwm_meas_pkg::ST_IDLE: begin
						state_q <= state_q;
					end
					pwm_meas_pkg::ST_WAIT: begin
						if (edge_ok && start_edge) begin
							state_q <= pwm_meas_pkg::ST_MEASURE;
						end
					end
					pwm_meas_pkg::ST_MEASURE: begin
						if (meas_end) begin
							if (oneshot) begin
								state_q <= pwm_meas_pkg::ST_HALTED;
							end else if (!chain) begin
								state_q <= pwm_meas_pkg::ST_WAIT;
							end
						end
					end
					pwm_meas_pkg::ST_HALTED: begin
						state_q <= state_q;
					end
				endcase
			end
		end
	end

	// ------------------------------------------------------------------
	// Counter
	// ------------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count_q <= pwm_meas_pkg::COUNT_CLEAR;
		end else if (clk_en) begin
			if (run_wr1 && (start_wr || state_q == pwm_meas_pkg::ST_MEASURE)) begin
				count_q <= pwm_meas_pkg::COUNT_CLEAR;
			end else if (meas_end && chain && !oneshot) begin
				count_q <= pwm_meas_pkg::COUNT_FIRST;
			end else if (state_q == pwm_meas_pkg::ST_WAIT && active && edge_ok
				&& start_edge) begin
				count_q <= pwm_meas_pkg::COUNT_FIRST;
			end else if (state_q == pwm_meas_pkg::ST_MEASURE && !meas_end && tick) begin
				count_q <= wrap ? pwm_meas_pkg::COUNT_CLEAR : count_q + 32'h0000_0001;
			end
		end
	end

	// ------------------------------------------------------------------
	// Result buffer
	// ------------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			buffer_q <= pwm_meas_pkg::COUNT_CLEAR;
		end else if (clk_en) begin
			if (meas_end && !oneshot) begin
				buffer_q <= count_q;
			end
		end
	end

	// ------------------------------------------------------------------
	// Status flags and enables
	// ------------------------------------------------------------------
	logic sts_wr;

	assign sts_wr = wr & sel_sts & pstrb[0];

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sts_q <= '0;
		end else if (clk_en) begin
			if (meas_end) begin
				sts_q.completion_flag <= 1'b1;
			end else if (buf_read) begin
				sts_q.completion_flag <= 1'b0;
			end
			if (meas_end && !oneshot && sts_q.completion_flag && !buf_read) begin
				sts_q.overrun <= 1'b1;
			end else if (buf_read) begin
				sts_q.overrun <= 1'b0;
			end
			if (wrap) begin
				sts_q.overflow_flag <= 1'b1;
			end else if (sts_wr && !pwdata[pwm_meas_pkg::STS_OVF_BIT]) begin
				sts_q.overflow_flag <= 1'b0;
			end
			if (sts_wr) begin
				sts_q.completion_irq_enable <= pwdata[pwm_meas_pkg::STS_DONE_IE_BIT];
				sts_q.overflow_irq_enable   <= pwdata[pwm_meas_pkg::STS_OVF_IE_BIT];
			end
		end
	end

	assign irq_overflow = sts_q.overflow_flag & sts_q.overflow_irq_enable;
	assign irq_complete = sts_q.completion_flag & sts_q.completion_irq_enable;

	// ------------------------------------------------------------------
	// Read data
	// ------------------------------------------------------------------
	logic [31:0] result_view;

	assign result_view = oneshot ? count_q : buffer_q;

	always_comb begin
		prdata = 32'h0000_0000;
		if (sel_ctl) begin
			prdata[pwm_meas_pkg::CTL_CKS_LSB +: 3]   = ctrl_q.clock_select[2:0];
			prdata[pwm_meas_pkg::CTL_EGS_LSB +: 3]   = ctrl_q.edge_select;
			prdata[pwm_meas_pkg::CTL_WIDE_BIT]       = ctrl_q.wide_pair_select;
			prdata[pwm_meas_pkg::CTL_FMD_LSB +: 3]   = ctrl_q.function_select;
			prdata[pwm_meas_pkg::CTL_ONESHOT_BIT]    = ctrl_q.oneshot_select;
			prdata[pwm_meas_pkg::CTL_RUN_BIT]        = ctrl_q.run_enable;
		end else if (sel_sts) begin
			prdata[pwm_meas_pkg::STS_CLOCK_SELECT_B3_BIT]    = ctrl_q.clock_select[3];
			prdata[pwm_meas_pkg::STS_ERR_BIT]     = sts_q.overrun;
			prdata[pwm_meas_pkg::STS_DONE_IE_BIT] = sts_q.completion_irq_enable;
			prdata[pwm_meas_pkg::STS_OVF_IE_BIT]  = sts_q.overflow_irq_enable;
			prdata[pwm_meas_pkg::STS_DONE_BIT]    = sts_q.completion_flag;
			prdata[pwm_meas_pkg::STS_OVF_BIT]     = sts_q.overflow_flag;
		end else if (sel_buf) begin
			prdata = wide ? result_view : {16'h0000, result_view[15:0]};
		end else if (sel_bufh) begin
			prdata = {16'h0000, result_view[31:16]};
		end
	end

endmodule

`default_nettype wire

// File: pulse_src.sv
// Far-side pulse source driving the measured input.
// Assumes the line is synchronous to pclk and idles low between bursts.
`timescale 1ns/10ps
`default_nettype none
module pulse_src (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        go,
	input  wire logic [17:0] hi_len,
	input  wire logic [15:0] lo_len,
	input  wire logic [3:0]  reps,
	output logic             pulse_out,
	output logic             busy
);
	logic [17:0] cnt_q;
	logic [3:0]  left_q;

	// ----------------------------------------
	// Burst of reps pulses, low lead-in first
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pulse_out <= 1'b0;
			cnt_q     <= '0;
			left_q    <= '0;
		end else if (go) begin
			pulse_out <= 1'b0;
			cnt_q     <= 18'h0_0004;
			left_q    <= reps;
		end else if (cnt_q > 18'h0_0001) begin
			cnt_q <= cnt_q - 18'h0_0001;
		end else if (cnt_q == 18'h0_0001) begin
			if (!pulse_out && left_q != 4'h0) begin
				pulse_out <= 1'b1;
				cnt_q     <= hi_len;
				left_q    <= left_q - 4'h1;
			end else if (pulse_out) begin
				pulse_out <= 1'b0;
				cnt_q     <= {2'b00, lo_len};
			end else begin
				cnt_q <= '0;
			end
		end
	end
	assign busy = cnt_q != 18'h0_0000;
endmodule
`default_nettype wire

// File: meas_timer_sva.sv
// Port checker for the pulse measurement timer channel.
// Assumes a bind onto the top module; one clock domain.
`timescale 1ns/10ps
`default_nettype none
module meas_timer_sva (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        clk_en,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	input  wire logic        pslverr,
	input  wire logic        pulse_in,
	input  wire logic        irq_overflow,
	input  wire logic        irq_complete
);
	wire logic   xfer;
	logic [4:0]  quiet_q;
	logic [16:0] run_q;
	logic        wsts_q;

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	assign xfer = psel && penable && pready;

	// ----------------------------------------
	// Cycles since input edge and control write
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			quiet_q <= '0;
			run_q   <= '0;
			wsts_q  <= 1'b0;
		end else begin
			quiet_q <= $changed(pulse_in) ? 5'h00 : quiet_q + {4'h0, quiet_q != 5'h1f};
			run_q   <= (xfer && pwrite && paddr == 8'h00) ? 17'h0_0000
				: run_q + {16'h0000, run_q != 17'h1_ffff};
			wsts_q  <= xfer && pwrite && paddr == 8'h04;
		end
	end

	sequence s_rd_buf;
		xfer && !pwrite && paddr == 8'h08;
	endsequence
	sequence s_wr_sts;
		xfer && pwrite && paddr == 8'h04 && pstrb[0];
	endsequence

	chk_ready_zero_wait: assert property (psel && !penable ##1 psel && penable && clk_en |-> pready)
		else $error("access phase not answered at once");
	chk_unmapped_err: assert property (psel && penable
		&& !(paddr inside {8'h00, 8'h04, 8'h08, 8'h0C}) |-> pslverr)
		else $error("unmapped access without error");
	chk_mapped_ok: assert property (psel && penable && (paddr inside {8'h00, 8'h04, 8'h08, 8'h0C})
		|-> !pslverr)
		else $error("mapped access flagged as error");
	chk_rd_clears_done: assert property (s_rd_buf ##0 (quiet_q > 5'h08) |=> !irq_complete)
		else $error("completion left set after buffer read");
	chk_ovf_clear_zero: assert property (s_wr_sts ##0 !pwdata[0] |=> !irq_overflow)
		else $error("overflow not cleared by writing zero");
	chk_ovf_ie_gate: assert property (s_wr_sts ##0 !pwdata[4] |=> !irq_overflow)
		else $error("overflow request while disabled");
	chk_done_ie_gate: assert property (s_wr_sts ##0 !pwdata[6] |=> !irq_complete)
		else $error("completion request while disabled");
	chk_done_after_edge: assert property ($rose(irq_complete) && !wsts_q |-> quiet_q <= 5'h06)
		else $error("completion without a recent input edge");
	chk_ovf_after_wrap: assert property ($rose(irq_overflow) && !wsts_q |-> run_q >= 17'h0_ffff)
		else $error("overflow before a full count");
endmodule
`default_nettype wire

// File: pulse_width_measurement_timer_tb.sv
// Self-checking bench for the pulse measurement timer channel.
// Assumes pwm_meas_pkg, pulse_src and meas_timer_sva are compiled first.
`timescale 1ns/10ps
`default_nettype none
module pulse_width_measurement_timer_tb;
	logic        pclk, presetn, psel, penable, pwrite, go, busy, pulse_in, last_err;
	logic        pready, pslverr, irq_overflow, irq_complete;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, r, r2;
	logic [17:0] hi_len;
	logic [15:0] lo_len;
	logic [3:0]  reps;
	int          bad_count, samples_checked, h, l;

	pulse_width_measurement_timer dut_u (.pclk, .presetn, .clk_en(1'b1), .psel, .penable,
		.pwrite, .paddr, .pwdata, .pstrb(4'hf), .prdata, .pready, .pslverr, .pulse_in,
		.irq_overflow, .irq_complete);
	pulse_src src_u (.pclk, .presetn, .go, .hi_len, .lo_len, .reps, .pulse_out(pulse_in), .busy);

	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end

	// ----------------------------------------
	// Bus, stimulus, comparison and closing tasks
	// ----------------------------------------
	task automatic fail(input string m);
		bad_count++;
		$display("[FAIL] %0t %s", $time, m);
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		samples_checked++;
		if (got !== exp)
			fail($sformatf("%s got %h exp %h", m, got, exp));
	endtask
	task automatic conclude;
		$display("checked %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		r        = prdata;
		last_err = pslverr;
		if (pready !== 1'b1) begin
			fail("bus timeout");
			conclude();
		end
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic pulses(input int hh, input int ll, input int k);
		hi_len <= 18'(hh);
		lo_len <= 16'(ll);
		reps   <= 4'(k);
		go     <= 1'b1;
		@(posedge pclk);
		go <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic settle;
		for (int n = 0; n < 80000 && busy === 1'b1; n++)
			@(posedge pclk);
		if (busy !== 1'b0) begin
			fail("source timeout");
			conclude();
		end
		repeat (6) @(posedge pclk);
	endtask
	function automatic logic [31:0] ctl(input logic [2:0] e, input logic os, input logic [2:0] ck);
		return (32'(ck) << pwm_meas_pkg::CTL_CKS_LSB) | (32'(e) << pwm_meas_pkg::CTL_EGS_LSB)
			| (32'(pwm_meas_pkg::FMD_PULSE_MEASURE) << pwm_meas_pkg::CTL_FMD_LSB)
			| (32'(os) << pwm_meas_pkg::CTL_ONESHOT_BIT) | (32'h0000_0001 << pwm_meas_pkg::CTL_RUN_BIT);
	endfunction
	function automatic logic [31:0] exp_n(input int e, input int hh, input int ll);
		case (e)
			1, 2: return 32'(hh + ll);
			4: return 32'(ll);
			default: return 32'(hh);
		endcase
	endfunction

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	initial begin
		{psel, penable, pwrite, go, presetn} = '0;
		paddr = '0;
		pwdata = '0;
		{hi_len, lo_len, reps} = '0;
		bad_count = 0;
		samples_checked = 0;
		void'($urandom(32'h85fd_f3e7));
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, 8'h00, 32'h0000_0000);
		chk(r, 32'h0000_0000, "control reset");
		apb(1'b0, 8'h04, 32'h0000_0000);
		chk(r, 32'h0000_0000, "status reset");
		apb(1'b0, 8'h10, 32'h0000_0000);
		chk({31'b0, last_err}, 32'h0000_0001, "unmapped");
		$display("reset test done");
		for (int e = 0; e < 5; e++) begin
			h = 3 + $urandom % 40;
			l = 3 + $urandom % 40;
			apb(1'b1, 8'h00, 32'h0000_0000);
			apb(1'b1, 8'h04, 32'h0000_0040);
			apb(1'b1, 8'h00, ctl(3'(e), 1'b0, 3'h0));
			pulses(h, l, 3);
			settle();
			apb(1'b0, 8'h04, 32'h0000_0000);
			chk(r, 32'h0000_00c4, "done and overrun");
			chk({31'b0, irq_complete}, 32'h0000_0001, "completion request");
			apb(1'b0, 8'h08, 32'h0000_0000);
			chk(r, exp_n(e, h, l), "width");
			apb(1'b0, 8'h04, 32'h0000_0000);
			chk(r, 32'h0000_0040, "flags cleared");
			$display("edge code %0d test done", e);
		end
		apb(1'b1, 8'h00, 32'h0000_0000);
		apb(1'b1, 8'h00, ctl(3'h0, 1'b1, 3'h0));
		pulses(60, 20, 3);
		repeat (30) @(posedge pclk);
		apb(1'b0, 8'h08, 32'h0000_0000);
		r2 = r;
		apb(1'b0, 8'h08, 32'h0000_0000);
		chk({31'b0, r > r2}, 32'h0000_0001, "live count");
		apb(1'b1, 8'h00, ctl(3'h0, 1'b1, 3'h0));
		apb(1'b0, 8'h08, 32'h0000_0000);
		chk(r, 32'h0000_0000, "restart clears");
		settle();
		apb(1'b0, 8'h04, 32'h0000_0000);
		chk(r, 32'h0000_0044, "single completion");
		apb(1'b0, 8'h08, 32'h0000_0000);
		chk(r, 32'h0000_003c, "held result");
		$display("one-shot test done");
		for (int k = 1; k < 3; k++) begin
			apb(1'b1, 8'h00, 32'h0000_0000);
			apb(1'b1, 8'h00, ctl(3'h0, 1'b0, 3'(k)));
			pulses(65, 8, 1);
			settle();
			apb(1'b0, 8'h08, 32'h0000_0000);
			chk(r, 32'(1 + (64 >> (2 * k))), "divided count");
		end
		$display("divider test done");
		apb(1'b1, 8'h00, 32'h0000_0000);
		apb(1'b1, 8'h00, ctl(3'h0, 1'b0, 3'h0) | (32'h0000_0001 << pwm_meas_pkg::CTL_WIDE_BIT));
		pulses(40, 8, 1);
		settle();
		apb(1'b0, 8'h08, 32'h0000_0000);
		chk(r, 32'h0000_0028, "wide result");
		apb(1'b0, 8'h0C, 32'h0000_0000);
		chk(r, 32'h0000_0000, "wide upper half");
		$display("wide test done");
		apb(1'b1, 8'h00, 32'h0000_0000);
		apb(1'b1, 8'h04, 32'h0000_0010);
		apb(1'b1, 8'h00, ctl(3'h0, 1'b0, 3'h0));
		pulses(65540, 4, 1);
		settle();
		chk({31'b0, irq_overflow}, 32'h0000_0001, "overflow request");
		apb(1'b1, 8'h04, 32'h0000_0011);
		apb(1'b0, 8'h04, 32'h0000_0000);
		chk(r, 32'h0000_0015, "one leaves flag");
		apb(1'b1, 8'h04, 32'h0000_0010);
		apb(1'b0, 8'h04, 32'h0000_0000);
		chk(r, 32'h0000_0014, "zero clears flag");
		apb(1'b0, 8'h08, 32'h0000_0000);
		chk(r, 32'h0000_0004, "wrapped count");
		$display("overflow test done");
		conclude();
	end
endmodule

bind pulse_width_measurement_timer meas_timer_sva chk_u (.pclk, .presetn, .clk_en, .psel,
	.penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .pulse_in,
	.irq_overflow, .irq_complete);
`default_nettype wire
